// File: hdl/jtc_pkg.sv
// constants, identity fields and carrier types of the jtag chain block
// assumes a 100 MHz core clock and a free-standing test clock from the host
package jtc_pkg;

    // ***********************************************
    // widths
    // ***********************************************
    localparam int JTC_IR_W = 4; // instruction register width
    localparam int JTC_DR_W = 32; // data register width
    localparam int JTC_NTAP = 2; // boundary-scan taps in the chain
    localparam int JTC_BOOT_W = 2; // boot mode strap width

    // ***********************************************
    // instruction codes
    // ***********************************************
    localparam logic [3:0] JTC_IR_EXTEST = 4'h0; // drive pins from boundary register
    localparam logic [3:0] JTC_IR_DEVICE_IDENTIFICATION_WORD = 4'h1; // identification word
    localparam logic [3:0] JTC_IR_USERCODE = 4'h2; // usercode word
    localparam logic [3:0] JTC_IR_SAMPLE = 4'h3; // sample pins
    localparam logic [3:0] JTC_IR_CHIP = 4'h4; // route data path to chip tap
    localparam logic [3:0] JTC_IR_BYPASS = 4'hF; // one-bit bypass
    localparam logic [3:0] JTC_IR_CAPT = 4'h1; // capture-ir pattern, lsbs 01

    // ***********************************************
    // identification word fields
    // ***********************************************
    localparam logic [3:0] JTC_ID_VERSION = 4'h1; // arbitrary value
    localparam logic [15:0] JTC_ID_PART = 16'h00A5; // arbitrary value
    localparam logic [10:0] JTC_ID_MAKER = 11'h055; // arbitrary value
    localparam logic JTC_ID_LSB = 1'b1; // fixed one
    localparam int JTC_UID_LSB = 22; // fused identity occupies [31:22]
    localparam int JTC_UID_W = 10; // fused identity width
    localparam logic [17:0] JTC_DIE_REV = 18'h00042; // arbitrary value
    localparam logic [3:0] JTC_UC_UNUSED = 4'h0; // usercode bits [21:18]
    localparam int JTC_SEC_NOJTAG = 0; // security bit blocking tile access
    localparam logic [31:0] JTC_SEC_RST = 32'h00000000; // unprogrammed security word

    // ***********************************************
    // types
    // ***********************************************
    typedef enum logic [3:0] {
        S_TLR, S_RTI, S_SELDR, S_CAPDR, S_SHDR, S_EX1DR, S_PADR, S_EX2DR,
        S_UPDR, S_SELIR, S_CAPIR, S_SHIR, S_EX1IR, S_PAIR, S_EX2IR, S_UPIR
    } jtc_tap_state_type;

    typedef enum logic [1:0] {
        P_REL, P_PLL, P_SEC, P_RUN
    } jtc_boot_phase_type;

    typedef struct packed {
        logic so; // serial out of the tap
        logic sh_dr; // in shift-dr
        logic sh_ir; // in shift-ir
        logic tlr; // in test-logic-reset
        logic drive; // boundary register drives pins
        logic [3:0] ir; // current instruction
        logic [31:0] bsr; // boundary update register
    } jtc_tap_out_type;

endpackage

// File: hdl/jtc_tap.sv
// one standard test access port: 16-state controller, 4-bit ir, 32-bit dr
// assumes tms, tdi and capture data are already in the tck domain
`timescale 1ns/100ps
module jtc_tap (
    // clock and reset
    input wire logic tck,
    input wire logic rst,
    // serial link
    input wire logic tms,
    input wire logic tdi,
    // capture sources
    input wire logic [31:0] id_word,
    input wire logic [31:0] user_word,
    input wire logic [31:0] pins_q,
    // results
    output jtc_pkg::jtc_tap_out_type tap_out
);
    import jtc_pkg::*;

    // ***********************************************
    // state
    // ***********************************************
    typedef struct packed {
        jtc_tap_state_type st; // controller state
        logic [3:0] ir_sh; // instruction shift register
        logic [3:0] ir; // instruction in force
        logic [31:0] dr_sh; // data shift register
        logic [31:0] bsr; // boundary update register
        logic drive; // extest in force, kept in a flop for the pin
    } jtc_tap_reg_type;

    jtc_tap_reg_type st_ff;
    jtc_tap_reg_type nxt_st;
    logic wide; // selected dr is 32 bits

    // ***********************************************
    // next state
    // ***********************************************
    // unknown codes fall into bypass so the chain length stays defined
    always_comb begin
        nxt_st = st_ff;
        wide = (st_ff.ir == JTC_IR_DEVICE_IDENTIFICATION_WORD) || (st_ff.ir == JTC_IR_USERCODE) ||
               (st_ff.ir == JTC_IR_EXTEST) || (st_ff.ir == JTC_IR_SAMPLE);
        case (st_ff.st)
            S_TLR: nxt_st.st = tms ? S_TLR : S_RTI;
            S_RTI: nxt_st.st = tms ? S_SELDR : S_RTI;
            S_SELDR: nxt_st.st = tms ? S_SELIR : S_CAPDR;
            S_CAPDR: nxt_st.st = tms ? S_EX1DR : S_SHDR;
            S_SHDR: nxt_st.st = tms ? S_EX1DR : S_SHDR;
            S_EX1DR: nxt_st.st = tms ? S_UPDR : S_PADR;
            S_PADR: nxt_st.st = tms ? S_EX2DR : S_PADR;
            S_EX2DR: nxt_st.st = tms ? S_UPDR : S_SHDR;
            S_UPDR: nxt_st.st = tms ? S_SELDR : S_RTI;
            S_SELIR: nxt_st.st = tms ? S_TLR : S_CAPIR;
            S_CAPIR: nxt_st.st = tms ? S_EX1IR : S_SHIR;
            S_SHIR: nxt_st.st = tms ? S_EX1IR : S_SHIR;
            S_EX1IR: nxt_st.st = tms ? S_UPIR : S_PAIR;
            S_PAIR: nxt_st.st = tms ? S_EX2IR : S_PAIR;
            S_EX2IR: nxt_st.st = tms ? S_UPIR : S_SHIR;
            S_UPIR: nxt_st.st = tms ? S_SELDR : S_RTI;
            default: nxt_st.st = S_TLR;
        endcase
        // actions of the state being left
        case (st_ff.st)
            S_CAPIR: begin
                nxt_st.ir_sh = JTC_IR_CAPT;
            end
            S_SHIR: begin
                nxt_st.ir_sh = {tdi, st_ff.ir_sh[3:1]};
            end
            S_UPIR: begin
                nxt_st.ir = st_ff.ir_sh;
            end
            S_CAPDR: begin
                case (st_ff.ir)
                    JTC_IR_DEVICE_IDENTIFICATION_WORD: nxt_st.dr_sh = id_word;
                    JTC_IR_USERCODE: nxt_st.dr_sh = user_word;
                    JTC_IR_EXTEST, JTC_IR_SAMPLE: nxt_st.dr_sh = pins_q;
                    default: nxt_st.dr_sh = 32'h00000000;
                endcase
            end
            S_SHDR: begin
                if (wide) begin
                    nxt_st.dr_sh = {tdi, st_ff.dr_sh[31:1]};
                end else begin
                    nxt_st.dr_sh[0] = tdi; // bypass bit
                end
            end
            S_UPDR: begin
                if (st_ff.ir == JTC_IR_EXTEST || st_ff.ir == JTC_IR_SAMPLE) begin
                    nxt_st.bsr = st_ff.dr_sh;
                end
            end
            default: begin
                nxt_st.ir_sh = st_ff.ir_sh;
            end
        endcase
        // device_identification_word is forced on entry, so a five-high reset drops extest at once and the chip path one tck later
        if (nxt_st.st == S_TLR) begin
            nxt_st.ir = JTC_IR_DEVICE_IDENTIFICATION_WORD;
        end
        nxt_st.drive = (nxt_st.ir == JTC_IR_EXTEST);
    end

    // ***********************************************
    // registers
    // ***********************************************
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            st_ff <= '{st: S_TLR, ir_sh: 4'h0, ir: JTC_IR_DEVICE_IDENTIFICATION_WORD, dr_sh: 32'h00000000, bsr: 32'h00000000,
                       drive: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ***********************************************
    // outputs: drive, ir and bsr straight from flops; state flags decoded and the serial mux
    // ***********************************************
    always_comb begin
        tap_out.sh_dr = (st_ff.st == S_SHDR);
        tap_out.sh_ir = (st_ff.st == S_SHIR);
        tap_out.so = tap_out.sh_ir ? st_ff.ir_sh[0] : st_ff.dr_sh[0];
        tap_out.tlr = (st_ff.st == S_TLR);
        tap_out.drive = st_ff.drive;
        tap_out.ir = st_ff.ir;
        tap_out.bsr = st_ff.bsr;
    end

endmodule // jtc_tap

// File: hdl/jtc_top.sv
// jtag chain of two boundary-scan taps with a path to the chip tap,
// plus global reset handling and boot sequencing.
// assumes the host drives tck/tms/tdi and samples tdo on rising tck.
`timescale 1ns/100ps
module jtc_top (
    // core clock and reset
    input wire logic core_clk,
    input wire logic clk_en,
    input wire logic rst,
    // chip reset and boot pins
    input wire logic chip_reset_n,
    input wire logic pll_lock_pin,
    input wire logic [jtc_pkg::JTC_BOOT_W-1:0] boot_mode_pin,
    // security word from the otp loader, core domain
    input wire logic [31:0] sec_word,
    input wire logic sec_valid,
    // jtag link
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // chip tap
    output logic chip_tms,
    output logic chip_tdi,
    output logic chip_sel,
    input wire logic chip_tdo,
    // boundary pins
    input wire logic [1:0][31:0] pins_in,
    output logic [1:0][31:0] bscan_out,
    output logic [1:0] bscan_drive,
    // boot sequencing
    output logic boot_start,
    output logic [jtc_pkg::JTC_BOOT_W-1:0] boot_mode,
    output logic sec_loaded
);
    import jtc_pkg::*;

    // ***********************************************
    // reset
    // ***********************************************
    // pin asserts without a clock; release is synchronised below in the core domain only, the tck domain takes it raw
    logic rst_any; // combined asynchronous reset
    assign rst_any = rst | ~chip_reset_n;

    // ***********************************************
    // core domain state
    // ***********************************************
    typedef struct packed {
        logic [1:0] rel_s; // reset release synchroniser
        logic [2:0] pll_s; // pll lock pin synchroniser
        logic pll_ok; // filtered lock
        logic [JTC_BOOT_W-1:0] mode; // strap caught at release
        jtc_boot_phase_type phase; // boot sequencing phase
        logic [31:0] sec; // security word copy
        logic sec_rdy; // security word stable
        logic start; // boot go
    } jtc_core_type;

    jtc_core_type core_ff;
    jtc_core_type nxt_core;

    // sequencing: release, lock, security load, boot
    always_comb begin
        nxt_core = core_ff;
        nxt_core.rel_s = {core_ff.rel_s[0], 1'b1};
        nxt_core.pll_s = {core_ff.pll_s[1:0], pll_lock_pin};
        // only an agreed second/third stage counts
        if (core_ff.pll_s[1] == core_ff.pll_s[2]) begin
            nxt_core.pll_ok = core_ff.pll_s[2];
        end
        case (core_ff.phase)
            P_REL: begin
                // strap is caught by a clocked step after release
                if (core_ff.rel_s[1]) begin
                    nxt_core.mode = boot_mode_pin;
                    nxt_core.phase = P_PLL;
                end
            end
            P_PLL: begin
                if (core_ff.pll_ok) begin
                    nxt_core.phase = P_SEC;
                end
            end
            P_SEC: begin
                if (sec_valid) begin
                    nxt_core.sec = sec_word;
                    nxt_core.sec_rdy = 1'b1;
                    nxt_core.phase = P_RUN;
                end
            end
            P_RUN: begin
                nxt_core.start = 1'b1;
            end
            default: begin
                nxt_core.phase = P_REL;
            end
        endcase
    end

    // clock enable freezes the whole core domain
    always_ff @(posedge core_clk or posedge rst_any) begin
        if (rst_any) begin
            core_ff <= '{rel_s: 2'h0, pll_s: 3'h0, pll_ok: 1'b0, mode: '0, phase: P_REL,
                         sec: JTC_SEC_RST, sec_rdy: 1'b0, start: 1'b0};
        end else if (clk_en) begin
            core_ff <= nxt_core;
        end
    end

    assign boot_start = core_ff.start;
    assign boot_mode = core_ff.mode;
    assign sec_loaded = core_ff.sec_rdy;

    // ***********************************************
    // tck domain state
    // ***********************************************
    typedef struct packed {
        logic [1:0] rdy_s; // sec_rdy level synchroniser
        logic [31:0] sec_q; // security word, taken once stable
        logic [2:0][1:0][31:0] pin_s; // pin synchroniser stages
        logic [1:0][31:0] pin_q; // filtered pins
        logic sel; // chip tap routed
        logic ctms; // tms to chip tap
        logic ctdi; // tdi to chip tap
    } jtc_link_type;

    jtc_link_type lnk_ff;
    jtc_link_type nxt_lnk;
    jtc_tap_out_type [1:0] tap_o; // per-tap results
    logic [1:0] tap_tdi; // serial in of each tap
    logic [31:0] id_word; // identification word
    logic [31:0] user_word; // usercode word
    logic blocked; // tile access fused off
    logic tdo_src; // serial source before the falling-edge flop
    logic [1:0][31:0] agree; // per-bit stage agreement

    // identity words
    assign id_word = {JTC_ID_VERSION, JTC_ID_PART, JTC_ID_MAKER, JTC_ID_LSB};
    // sec_q stays zero until loaded, and an unburnt fuse word is zero too
    assign user_word = {lnk_ff.sec_q[31:JTC_UID_LSB], JTC_UC_UNUSED, JTC_DIE_REV};
    assign blocked = lnk_ff.sec_q[JTC_SEC_NOJTAG];

    // chain wiring: tdi -> tap0 -> tap1 -> tdo
    assign tap_tdi[0] = tdi;
    assign tap_tdi[1] = tap_o[0].so;

    // ***********************************************
    // the two boundary-scan taps
    // ***********************************************
    genvar gi;
    generate
        for (gi = 0; gi < JTC_NTAP; gi++) begin : g_tap
            jtc_tap u_tap (
                .tck(tck),
                .rst(rst_any),
                .tms(tms),
                .tdi(tap_tdi[gi]),
                .id_word(id_word),
                .user_word(user_word),
                .pins_q(lnk_ff.pin_q[gi]),
                .tap_out(tap_o[gi])
            );
            assign bscan_out[gi] = tap_o[gi].bsr;
            assign bscan_drive[gi] = tap_o[gi].drive;
            assign agree[gi] = ~(lnk_ff.pin_s[1][gi] ^ lnk_ff.pin_s[2][gi]);
        end
    endgenerate

    // link next state: crossings, pin filter, chip tap routing
    always_comb begin
        nxt_lnk = lnk_ff;
        nxt_lnk.rdy_s = {lnk_ff.rdy_s[0], core_ff.sec_rdy};
        // the word is static once its ready level arrives
        if (lnk_ff.rdy_s[1]) begin
            nxt_lnk.sec_q = core_ff.sec;
        end
        nxt_lnk.pin_s = {lnk_ff.pin_s[1:0], pins_in};
        nxt_lnk.pin_q = (lnk_ff.pin_q & ~agree) | (lnk_ff.pin_s[2] & agree);
        // a fused-off tile sees the chip tap deselected from one tck after sec_q holds its word
        nxt_lnk.sel = (tap_o[1].ir == JTC_IR_CHIP) && !blocked;
        // a deselected chip tap is parked in reset by tms high
        nxt_lnk.ctms = nxt_lnk.sel ? tms : 1'b1;
        nxt_lnk.ctdi = tap_o[0].so;
    end

    always_ff @(posedge tck or posedge rst_any) begin
        if (rst_any) begin
            lnk_ff <= '{rdy_s: 2'h0, sec_q: JTC_SEC_RST, pin_s: '0, pin_q: '0,
                        sel: 1'b0, ctms: 1'b1, ctdi: 1'b0};
        end else begin
            lnk_ff <= nxt_lnk;
        end
    end

    assign chip_sel = lnk_ff.sel;
    assign chip_tms = lnk_ff.ctms;
    assign chip_tdi = lnk_ff.ctdi;

    // ***********************************************
    // tdo on the falling edge
    // ***********************************************
    // falling edge gives the host a half period of setup
    assign tdo_src = (lnk_ff.sel && tap_o[1].sh_dr) ? chip_tdo : tap_o[1].so;

    always_ff @(negedge tck or posedge rst_any) begin
        if (rst_any) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo <= tdo_src;
            tdo_oe <= tap_o[1].sh_dr | tap_o[1].sh_ir;
        end
    end

endmodule // jtc_top

// File: tb/jtc_top_assertions.sv
// checker for the jtag chain top: link framing, pin reset, boot order
// assumes it is bound onto jtc_top and sees only that module's ports
`timescale 1ns/100ps
module jtc_top_assertions (
    // clocks and resets
    input wire logic core_clk,
    input wire logic tck,
    input wire logic rst,
    input wire logic chip_reset_n,
    // boot side
    input wire logic pll_lock_pin,
    input wire logic [31:0] sec_word,
    input wire logic sec_valid,
    input wire logic boot_start,
    input wire logic [jtc_pkg::JTC_BOOT_W-1:0] boot_mode,
    input wire logic sec_loaded,
    // link side
    input wire logic tms,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic chip_tms,
    input wire logic chip_sel,
    input wire logic [1:0] bscan_drive
);
    import jtc_pkg::*;
    // link reset, idle, then straight into shift-dr
    sequence to_shdr;
        tms [*5] ##1 !tms ##1 tms ##1 !tms [*2];
    endsequence
    // link reset, idle, then straight into shift-ir
    sequence to_shir;
        tms [*5] ##1 !tms ##1 tms [*2] ##1 !tms [*2];
    endsequence
    a_pin_clears_boot: assert property (@(posedge core_clk) disable iff (rst)
        !chip_reset_n |-> !boot_start && !sec_loaded && bscan_drive == 2'h0)
        else $error("boot state alive under pin reset");
    a_boot_after_lock: assert property (@(posedge core_clk) disable iff (rst || !chip_reset_n)
        $rose(boot_start) |-> $past(pll_lock_pin, 3))
        else $error("boot began before lock");
    a_boot_after_sec: assert property (@(posedge core_clk) disable iff (rst || !chip_reset_n)
        $rose(boot_start) |-> $past(sec_valid))
        else $error("boot began before security word");
    a_boot_holds: assert property (@(posedge core_clk) disable iff (rst || !chip_reset_n)
        boot_start |=> boot_start && $stable(boot_mode))
        else $error("boot state dropped or mode moved");
    a_five_high_reset: assert property (@(posedge tck) disable iff (rst || !chip_reset_n)
        tms [*5] |-> ##2 !chip_sel && bscan_drive == 2'h0)
        else $error("five tms highs left an instruction active");
    a_sec_blocks_chip: assert property (@(posedge tck) disable iff (rst || !chip_reset_n)
        $past(sec_loaded, 3) && sec_word[JTC_SEC_NOJTAG] |-> !chip_sel)
        else $error("chip path open while blocked");
    a_chip_tms_idle: assert property (@(posedge tck) disable iff (rst || !chip_reset_n)
        !chip_sel [*2] |-> chip_tms)
        else $error("chip tms moved while deselected");
    a_device_identification_word_first: assert property (@(posedge tck) disable iff (rst || !chip_reset_n)
        to_shdr |=> tdo_oe && tdo == JTC_ID_LSB)
        else $error("first dr bit after reset not the id one");
    a_ir_capture: assert property (@(posedge tck) disable iff (rst || !chip_reset_n)
        to_shir |=> tdo_oe && tdo == JTC_IR_CAPT[0])
        else $error("first ir bit not the capture pattern");
endmodule // jtc_top_assertions

bind jtc_top jtc_top_assertions u_jtc_top_assertions (.core_clk, .tck, .rst, .chip_reset_n,
    .pll_lock_pin, .sec_word, .sec_valid, .boot_start, .boot_mode, .sec_loaded,
    .tms, .tdo, .tdo_oe, .chip_tms, .chip_sel, .bscan_drive);

// File: tb/jtc_host.sv
// host side of the jtag link: tck runs only inside frames
// assumes the device samples on rising tck and moves tdo on falling tck
`timescale 1ns/100ps
module jtc_host (
    // link to the device
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    // tck parked low between frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one bit: drive, sample tdo just before the rise, then fall
    task automatic bit1(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #16;
        o = tdo;
        tck = 1'b1;
        #16;
        tck = 0;
    endtask
    // state move only; tdi toggles as nobody reads it here
    task automatic step(input logic m);
        logic o;
        bit1(m, ~tdi, o);
    endtask
    // five highs from anywhere, then park in idle
    task automatic reset_tap();
        repeat (5) step(1'b1);
        step(1'b0);
    endtask
    // from idle: ir or dr scan of n bits, lsb first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
        logic o;
        dout = 64'h0;
        step(1'b1);
        if (ir) step(1'b1);
        step(1'b0);
        step(1'b0);
        for (int i = 0; i < n; i++) begin
            bit1(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1);
        step(1'b0);
    endtask
    // idle clocks, used to let registered chip select settle
    task automatic idle(input int k);
        repeat (k) step(1'b0);
    endtask
endmodule // jtc_host

// File: tb/test_jtag_chain_and_chip_reset.sv
// bench for the jtag chain: id and usercode reads, bypass, extest,
// chip path and its block, boot order and pin reset
// assumes jtc_pkg, jtc_top, jtc_host and the bound checker are compiled
`timescale 1ns/100ps
module test_jtag_chain_and_chip_reset;
    import jtc_pkg::*;
    logic core_clk, clk_en, rst, chip_reset_n, pll_lock_pin, sec_valid, boot_start, sec_loaded;
    logic [JTC_BOOT_W-1:0] boot_mode_pin, boot_mode;
    logic [31:0] sec_word;
    logic tck, tms, tdi, tdo, tdo_oe, chip_tms, chip_tdi, chip_sel, chip_tdo;
    logic [1:0][31:0] pins_in, bscan_out;
    logic [1:0] bscan_drive;
    logic [63:0] got, d;
    int seed = 32'h3ADE5CD9;
    int n_errors = 0;
    int n_checks = 0;
    jtc_top u_jtc_top (.core_clk, .clk_en, .rst, .chip_reset_n, .pll_lock_pin, .boot_mode_pin,
        .sec_word, .sec_valid, .tck, .tms, .tdi, .tdo, .tdo_oe, .chip_tms, .chip_tdi, .chip_sel,
        .chip_tdo, .pins_in, .bscan_out, .bscan_drive, .boot_start, .boot_mode, .sec_loaded);
    jtc_host u_jtc_host (.tck, .tms, .tdi, .tdo);
    // core clock, 100 MHz
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // noise on pins and chip return; clk_en low a quarter of the time
    always @(posedge core_clk) begin
        pins_in <= {$random(seed), $random(seed)};
        chip_tdo <= 1'($random(seed));
        clk_en <= ($random(seed) & 3) != 0;
    end
    // expected words from the field constants
    function automatic logic [31:0] id_word();
        return {JTC_ID_VERSION, JTC_ID_PART, JTC_ID_MAKER, JTC_ID_LSB};
    endfunction
    function automatic logic [31:0] uc_word(input logic [31:0] s);
        return {s[31:22], JTC_UC_UNUSED, JTC_DIE_REV};
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // same code into both taps, capture pattern comes back
    task automatic ir(input logic [3:0] c);
        u_jtc_host.scan(1'b1, 8, {56'h0, c, c}, got);
        chk(got[7:0], {JTC_IR_CAPT, JTC_IR_CAPT});
    endtask
    task automatic dr64();
        u_jtc_host.scan(1'b0, 64, 64'h0, got);
    endtask
    // bounded wait; clk_en gaps stretch the boot path
    task automatic wait_boot();
        for (int i = 0; i < 300 && boot_start !== 1'b1; i++) @(posedge core_clk);
        chk(boot_start, 1'b1);
    endtask
    task automatic summarize();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        chip_reset_n = 1'b0;
        pll_lock_pin = 1'b0;
        sec_valid = 1'b0;
        sec_word = $random(seed) & 32'hFFFFFFFE;
        boot_mode_pin = 2'($random(seed));
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        repeat (6) @(posedge core_clk);
        chip_reset_n <= 1'b1;
        u_jtc_host.reset_tap();
        dr64();
        chk(got, {2{id_word()}});
        // a loaded usercode is dropped by five tms highs
        ir(JTC_IR_USERCODE);
        u_jtc_host.reset_tap();
        dr64();
        chk(got, {2{id_word()}});
        // before the security word lands the identity reads zero
        ir(JTC_IR_USERCODE);
        dr64();
        chk(got, {2{uc_word(JTC_SEC_RST)}});
        // no boot without lock, nor without the security word
        repeat (40) @(posedge core_clk);
        chk(boot_start, 1'b0);
        pll_lock_pin <= 1'b1;
        repeat (40) @(posedge core_clk);
        chk(boot_start, 1'b0);
        sec_valid <= 1'b1;
        wait_boot();
        chk({boot_start, boot_mode}, {1'b1, boot_mode_pin});
        // fused identity in the upper usercode bits
        u_jtc_host.reset_tap();
        ir(JTC_IR_USERCODE);
        dr64();
        chk(got, {2{uc_word(sec_word)}});
        // bypass and an unknown code each give one zero bit per tap
        d = {$random(seed), $random(seed)};
        for (int k = 0; k < 2; k++) begin
            ir(k == 0 ? JTC_IR_BYPASS : 4'hA);
            u_jtc_host.scan(1'b0, 8, d, got);
            chk(got[7:0], {d[5:0], 2'b00});
        end
        // extest: tap1 keeps the first 32 bits shifted in
        ir(JTC_IR_EXTEST);
        u_jtc_host.scan(1'b0, 64, d, got);
        chk(bscan_drive, 2'h3);
        chk({bscan_out[1], bscan_out[0]}, {d[31:0], d[63:32]});
        // five tms highs leave extest without any ir scan
        u_jtc_host.reset_tap();
        chk(bscan_drive, 2'h0);
        ir(JTC_IR_CHIP);
        u_jtc_host.idle(3);
        chk(chip_sel, 1'b1);
        // pin reset between clock edges clears at once
        @(posedge core_clk);
        #3 chip_reset_n = 1'b0;
        #1 chk({boot_start, sec_loaded, chip_sel, bscan_drive, chip_tdi, tdo_oe, chip_tms}, 8'h01);
        chk(bscan_out, 64'h0);
        sec_word = $random(seed) | 32'h1;
        repeat (12) @(posedge core_clk);
        chip_reset_n <= 1'b1;
        wait_boot();
        u_jtc_host.reset_tap();
        ir(JTC_IR_CHIP);
        u_jtc_host.idle(3);
        chk(chip_sel, 1'b0);
        summarize();
    end
    // far longer than the planned scans and boots
    initial begin
        #200000;
        n_errors++;
        summarize();
    end
endmodule // test_jtag_chain_and_chip_reset
